// ---- bench/pio_assertions.sv ----
// checker: port properties of the io pin logic
`timescale 1ns/1ps
`default_nettype none
module pio_assertions (
  input wire logic clk_in, rst_in, pin_one_function_select_in, out_two_buffer_type_in,
  input wire logic core_rail_reset_enable_in, pin_one_user_bit_in, pin_two_user_bit_in,
  input wire logic pin_one_seq_ctrl_in, dcdc_reset_pin_in, rails_power_good_in,
  input wire logic any_rail_enabled_in, main_power_good_out, ddr_reset_in_pin_oe_out,
  input wire logic ddr_reset_out_pin_oe_out, dcdc_reset_pin_oe_out,
  input wire logic core_buck_a_restore_out, core_buck_b_restore_out
);
  wire s1 = pin_one_function_select_in;
  wire e3 = core_rail_reset_enable_in;
  wire ra = core_buck_a_restore_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  AST_ONE: assert property (!s1 && !pin_one_seq_ctrl_in |=>
    ddr_reset_in_pin_oe_out == !$past(pin_one_user_bit_in)) else $error("pin one");
  AST_ONE_IN: assert property (s1 |=> !ddr_reset_in_pin_oe_out) else $error("pin one in");
  AST_TWO: assert property (!s1 |=> ddr_reset_out_pin_oe_out ==
    ($past(out_two_buffer_type_in) || !$past(pin_two_user_bit_in))) else $error("pin two");
  AST_THREE_IN: assert property (e3 |=> !dcdc_reset_pin_oe_out) else $error("pin three");
  AST_PWR_GOOD: assert property (1 |=> main_power_good_out ==
    $past(rails_power_good_in && any_rail_enabled_in)) else $error("power good");
  AST_EDGE: assert property (e3 && $fell(dcdc_reset_pin_in) ##1 !dcdc_reset_pin_in |->
    ##[1:3] ra) else $error("no restore");
  AST_PULSE: assert property (ra |=> !ra) else $error("long restore");
  AST_PAIR: assert property ($rose(ra) |-> $rose(core_buck_b_restore_out)) else $error("pair");
endmodule
`default_nettype wire

// ---- bench/pio_host.sv ----
// host model: two reset lines with pull-ups, host or device may pull low
`timescale 1ns/1ps
`default_nettype none
module pio_host (
  input  wire logic [1:0] low_in,
  input  wire logic [1:0] oe_in,
  input  wire logic [1:0] o_in,
  output var  logic [1:0] pin_out
);
  // host pulls low, a released line reads high
  assign pin_out = ~low_in & ~(oe_in & ~o_in);
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// testbench: io pin logic against a host on both reset lines
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t mismatch", $time); end end
module tb_top;
  logic clk_in = 0, rst_in = 1, clk_en_in = 1, pin_one_function_select_in = 0;
  logic out_two_buffer_type_in = 0, core_rail_reset_enable_in = 0, ddr_latch_mode_in = 0;
  logic pin_one_user_bit_in = 1, pin_two_user_bit_in = 1, pin_three_user_bit_in = 0;
  logic pin_one_seq_ctrl_in = 0, pin_one_seq_level_in = 0, pin_three_seq_ctrl_in = 0;
  logic pin_three_seq_level_in = 0, latch_clear_in = 0, rails_power_good_in = 1;
  logic any_rail_enabled_in = 0, mem_low = 0, core_low = 0;
  wire ddr_reset_in_pin_in, ddr_reset_in_pin_out, ddr_reset_in_pin_oe_out, dcdc_reset_pin_in;
  wire ddr_reset_out_pin_out, ddr_reset_out_pin_oe_out, dcdc_reset_pin_out, main_power_good_out;
  wire dcdc_reset_pin_oe_out, core_buck_a_restore_out, core_buck_b_restore_out;
  int bad_count = 0, check_count = 0, pulses = 0;
  pio_pins dut_u (.*);
  pio_host host_u (.low_in({core_low, mem_low}), .oe_in({dcdc_reset_pin_oe_out,
    ddr_reset_in_pin_oe_out}), .o_in({dcdc_reset_pin_out, ddr_reset_in_pin_out}),
    .pin_out({dcdc_reset_pin_in, ddr_reset_in_pin_in}));
  always #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) pulses += (core_buck_a_restore_out === 1'b1);
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask
  // pin path is three cycles, so each look in this task waits that long
  task automatic two(input logic oe, input logic o);
    step(3);
    `CHK(ddr_reset_out_pin_oe_out, oe)
    `CHK(ddr_reset_out_pin_out, o)
  endtask
  task automatic t_gp;
    for (int i = 0; i < 4; i++) begin
      {out_two_buffer_type_in, pin_two_user_bit_in} = 2'(i);
      pin_one_user_bit_in = i[0];
      two(i[1] | !i[0], i[1] & i[0]);
      `CHK(ddr_reset_in_pin_in, i[0])
    end
    pin_one_seq_ctrl_in = 1;
    step(2);
    `CHK(ddr_reset_in_pin_in, 1'b0)
  endtask
  task automatic t_three;
    `CHK(dcdc_reset_pin_in, 1'b0)
    pin_three_user_bit_in = 1;
    for (int k = 0; k < 3; k++) begin
      core_rail_reset_enable_in = k > 0;
      core_low = 1;
      step(5);
      core_low = 0;
      step(5);
    end
    `CHK(pulses, 2)
  endtask
  task automatic t_pass;
    pin_one_function_select_in = 1;
    out_two_buffer_type_in = 0;
    two(1'b1, 1'b0);
    any_rail_enabled_in = 1;
    two(1'b0, 1'b0);
    out_two_buffer_type_in = 1;
    two(1'b1, 1'b1);
    mem_low = 1;
    two(1'b1, 1'b0);
    ddr_latch_mode_in = 1;
    mem_low = 0;
    two(1'b1, 1'b0);
    latch_clear_in = 1;
    two(1'b1, 1'b1);
    latch_clear_in = 0;
    rails_power_good_in = 0;
    step(2);
    `CHK(main_power_good_out, 1'b0)
  endtask
  task end_sim;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    step(16);
    rst_in = 0;
    step(1);
    `CHK(main_power_good_out, 1'b0)
    t_gp();
    t_three();
    t_pass();
    end_sim();
  end
  // watchdog: the run needs about 80 cycles
  initial begin
    #20000;
    bad_count++;
    end_sim();
  end
endmodule
bind pio_pins pio_assertions chk_u (.*);
`default_nettype wire

// ---- rtl/pio_pins.sv ----
// io pin logic: memory reset in/out pins and core rail reset pin
//
// Function
// - two two-way pins and one output pin, set by stored and user bits
// - select 0: first pin open-drain, low for user bit 0, released for 1
// - first pin as output follows its user bit or the power sequencer
// - select 1: first pin is host memory reset, latched or passed to second pin
// - select 0, buffer 0: second pin open-drain from its user bit
// - select 0, buffer 1: second pin push-pull from its user bit
// - select 1: second pin ignores user bit, driven from first pin and power good
// - second pin buffer is open-drain or push-pull
// - third pin as output is open-drain from its user bit or sequencer
// - third pin alternate use resets only the two core buck converters
// - enable 0: third pin output from user bit; enable 1: active-low reset input
// - falling edge on third pin restores only the two core buck voltages
// - select 1 makes first pin an input and second pin an output
// - power good is low after reset and low when all rails are off
`timescale 1ns/1ps
`default_nettype none
module pio_pins (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic clk_en_in,
  // stored selection bits
  input  wire logic pin_one_function_select_in,
  input  wire logic out_two_buffer_type_in,
  input  wire logic core_rail_reset_enable_in,
  input  wire logic ddr_latch_mode_in,
  // user bits and sequencer controls
  input  wire logic pin_one_user_bit_in,
  input  wire logic pin_two_user_bit_in,
  input  wire logic pin_three_user_bit_in,
  input  wire logic pin_one_seq_ctrl_in,
  input  wire logic pin_one_seq_level_in,
  input  wire logic pin_three_seq_ctrl_in,
  input  wire logic pin_three_seq_level_in,
  input  wire logic latch_clear_in,
  // power state
  input  wire logic rails_power_good_in,
  input  wire logic any_rail_enabled_in,
  // pins
  input  wire logic ddr_reset_in_pin_in,
  output var  logic ddr_reset_in_pin_out,
  output var  logic ddr_reset_in_pin_oe_out,
  output var  logic ddr_reset_out_pin_out,
  output var  logic ddr_reset_out_pin_oe_out,
  input  wire logic dcdc_reset_pin_in,
  output var  logic dcdc_reset_pin_out,
  output var  logic dcdc_reset_pin_oe_out,
  // status and core rail reset
  output var  logic main_power_good_out,
  output var  logic core_buck_a_restore_out,
  output var  logic core_buck_b_restore_out
);
  logic          ddr_in_s;
  logic          dcdc_s;
  logic          dcdc_prev_q;
  logic          dcdc_prev_d;
  logic          pwr_good_q;
  logic          pwr_good_d;
  logic          latch_q;
  logic          latch_d;
  logic          restore_q;
  logic          restore_d;
  logic          one_lvl_q;
  logic          one_lvl_d;
  logic          one_oe_q;
  logic          one_oe_d;
  logic          two_lvl_q;
  logic          two_lvl_d;
  logic          two_oe_q;
  logic          two_oe_d;
  logic          three_lvl_q;
  logic          three_lvl_d;
  logic          three_oe_q;
  logic          three_oe_d;
  logic          one_level;
  logic          two_level;
  logic          three_level;
  pio_pkg::pio_ddr_mode_e mode;

  // pins come from outside the clock domain
  pio_sync u_sync_ddr (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .en_in  (clk_en_in),
    .d_in   (ddr_reset_in_pin_in),
    .q_out  (ddr_in_s)
  );

  pio_sync u_sync_dcdc (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .en_in  (clk_en_in),
    .d_in   (dcdc_reset_pin_in),
    .q_out  (dcdc_s)
  );

  always_comb begin
    mode = ddr_latch_mode_in ? pio_pkg::PIO_MODE_LATCH : pio_pkg::PIO_MODE_PASS;
    pwr_good_d = rails_power_good_in & any_rail_enabled_in;
    one_level = pin_one_seq_ctrl_in ? pin_one_seq_level_in : pin_one_user_bit_in;
    three_level = pin_three_seq_ctrl_in ? pin_three_seq_level_in : pin_three_user_bit_in;
    // latch host reset; a low is held until cleared, the low wins over a clear
    latch_d = latch_q;
    if (!ddr_in_s) begin
      latch_d = 1'b1;
    end else if (latch_clear_in) begin
      latch_d = 1'b0;
    end
    // second pin from input and power good in select 1, from its user bit in select 0
    if (pin_one_function_select_in == pio_pkg::FN_RESET_INPUT) begin
      unique case (mode)
        pio_pkg::PIO_MODE_PASS:  two_level = pwr_good_q & ddr_in_s;
        pio_pkg::PIO_MODE_LATCH: two_level = pwr_good_q & ~latch_q;
      endcase
    end else begin
      two_level = pin_two_user_bit_in;
    end
    one_lvl_d = 1'b0;
    one_oe_d  = (pin_one_function_select_in == pio_pkg::FN_GP_OUTPUT) & ~one_level;
    // buffer type picks drive style
    // open-drain keeps the data line low so a released pin never drives high
    two_lvl_d = (out_two_buffer_type_in == pio_pkg::BUF_PUSH_PULL) & two_level;
    two_oe_d  = (out_two_buffer_type_in == pio_pkg::BUF_PUSH_PULL) | ~two_level;
    three_lvl_d = 1'b0;
    three_oe_d  = ~core_rail_reset_enable_in & ~three_level;
    dcdc_prev_d = dcdc_s;
    restore_d   = core_rail_reset_enable_in & dcdc_prev_q & ~dcdc_s;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pwr_good_q  <= pio_pkg::RST_PWR_GOOD;
      latch_q     <= pio_pkg::RST_LATCH;
      dcdc_prev_q <= pio_pkg::RST_PIN_LEVEL;
      restore_q   <= 1'b0;
      one_lvl_q   <= 1'b0;
      one_oe_q    <= 1'b0;
      two_lvl_q   <= 1'b0;
      two_oe_q    <= 1'b0;
      three_lvl_q <= 1'b0;
      three_oe_q  <= 1'b0;
    end else if (clk_en_in) begin
      pwr_good_q  <= pwr_good_d;
      latch_q     <= latch_d;
      dcdc_prev_q <= dcdc_prev_d;
      restore_q   <= restore_d;
      one_lvl_q   <= one_lvl_d;
      one_oe_q    <= one_oe_d;
      two_lvl_q   <= two_lvl_d;
      two_oe_q    <= two_oe_d;
      three_lvl_q <= three_lvl_d;
      three_oe_q  <= three_oe_d;
    end
  end

  assign ddr_reset_in_pin_out     = one_lvl_q;
  assign ddr_reset_in_pin_oe_out  = one_oe_q;
  assign ddr_reset_out_pin_out    = two_lvl_q;
  assign ddr_reset_out_pin_oe_out = two_oe_q;
  assign dcdc_reset_pin_out       = three_lvl_q;
  assign dcdc_reset_pin_oe_out    = three_oe_q;
  assign main_power_good_out      = pwr_good_q;
  assign core_buck_a_restore_out  = restore_q;
  assign core_buck_b_restore_out  = restore_q;
endmodule
`default_nettype wire

// ---- rtl/pio_pkg.sv ----
// package: constants and types for the pmic io pin logic
package pio_pkg;
  // buffer type codes for the second output
  localparam logic       BUF_OPEN_DRAIN = 1'b0;
  localparam logic       BUF_PUSH_PULL  = 1'b1;
  // function select codes for the first pin
  localparam logic       FN_GP_OUTPUT   = 1'b0;
  localparam logic       FN_RESET_INPUT = 1'b1;
  // reset values
  localparam logic       RST_USER_BIT   = 1'b1;
  localparam logic       RST_PWR_GOOD   = 1'b0;
  localparam logic       RST_PIN_LEVEL  = 1'b1;
  localparam logic [1:0] RST_SYNC       = 2'b11;
  localparam logic       RST_LATCH      = 1'b0;
  // pass-through mode versus latched mode of the memory reset path
  typedef enum logic [1:0] {
    PIO_MODE_PASS  = 2'b01,
    PIO_MODE_LATCH = 2'b10
  } pio_ddr_mode_e;
endpackage

// ---- rtl/pio_sync.sv ----
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
`default_nettype none
module pio_sync (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic en_in,
  input  wire logic d_in,
  output var  logic q_out
);
  logic [1:0] sync_q;
  logic [1:0] sync_d;

  always_comb begin
    sync_d = en_in ? {sync_q[0], d_in} : sync_q;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_q <= pio_pkg::RST_SYNC;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign q_out = sync_q[1];
endmodule
`default_nettype wire
